// [verification/odl_dlte.sv]
/*
  Behavioural data-link terminal equipment facing the overhead port.
  Assumes the port drives both overhead clocks and holds them low when idle.
*/
module odl_dlte #(
  parameter logic [7:0] PATTERN = 8'hB2
) (
  input  wire logic rx_overhead_clock,
  input  wire logic rx_overhead_data_out,
  input  wire logic tx_overhead_clock,
  output logic      tx_overhead_data_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic rx_got[$];
  int   idx;
  initial begin
    tx_overhead_data_in = 1'b1;
    idx = 0;
  end
  always @(negedge rx_overhead_clock) rx_got.push_back(rx_overhead_data_out);
  // data stays put from one rise to the next, so the fall always sees a settled bit
  always @(posedge tx_overhead_clock) begin
    tx_overhead_data_in <= PATTERN[idx % 8];
    idx++;
  end
endmodule

// [verification/tb_odl_port.sv]
/*
  Self-checking bench for the overhead data-link port: APB registers, link
  position selection, tx sources, rx destinations and the rx FIFO.
  Assumes the framer core is played by this bench on pclk.
*/
module tb_odl_port;
  timeunit 1ns;
  timeprecision 1ps;
  import odl_pkg::*;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, tx_dl_valid, tx_dl_bit, tx_overhead_data_in, tx_overhead_clock;
  logic rx_core_ready, rx_lapd_valid, rx_lapd_bit, rx_serial_payload_out;
  logic rx_overhead_clock, rx_overhead_data_out;
  logic tx_lapd_bit = 1'b0, tx_serial_payload_in = 1'b0;
  odl_fmt_e fmt = ODL_FMT_T1DM;
  odl_pos_s tx_pos = '0, rx_pos = '0;
  int miscompares = 0, total_checks = 0;
  int n_txclk = 0, n_rxclk = 0, n_txv = 0, n_lapd = 0;
  logic p_tx = 1'b0, p_rx = 1'b0, ser_seen, lapd_seen;

  always #20 pclk = ~pclk;

  odl_port DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .fmt(fmt), .tx_pos(tx_pos), .tx_lapd_bit(tx_lapd_bit),
    .tx_dl_valid(tx_dl_valid), .tx_dl_bit(tx_dl_bit),
    .tx_serial_payload_in(tx_serial_payload_in), .tx_overhead_data_in(tx_overhead_data_in),
    .tx_overhead_clock(tx_overhead_clock), .rx_pos(rx_pos), .rx_core_ready(rx_core_ready),
    .rx_lapd_valid(rx_lapd_valid), .rx_lapd_bit(rx_lapd_bit),
    .rx_serial_payload_out(rx_serial_payload_out), .rx_overhead_clock(rx_overhead_clock),
    .rx_overhead_data_out(rx_overhead_data_out));

  odl_dlte far_end (.rx_overhead_clock(rx_overhead_clock),
    .rx_overhead_data_out(rx_overhead_data_out), .tx_overhead_clock(tx_overhead_clock),
    .tx_overhead_data_in(tx_overhead_data_in));

  always @(posedge pclk) begin
    p_tx <= tx_overhead_clock;
    p_rx <= rx_overhead_clock;
    if (tx_overhead_clock === 1'b1 && p_tx === 1'b0) n_txclk++;
    if (rx_overhead_clock === 1'b1 && p_rx === 1'b0) n_rxclk++;
    if (tx_dl_valid === 1'b1) n_txv++;
    if (rx_lapd_valid === 1'b1) n_lapd++;
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic err);
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // no wait count assumed: only the watchdog ends a hung access
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic setup(input logic [7:0] txv, input logic [7:0] rxv);
    logic [31:0] rd;
    logic e;
    apb(1'b1, TX_SEL_OFFS, {24'h0, txv}, rd, e);
    apb(1'b1, RX_SEL_OFFS, {24'h0, rxv}, rd, e);
  endtask

  // one bit position on both directions, 11 cycles apart to respect the drain rate
  task automatic step(input logic o, input logic [4:0] f, input logic b);
    @(posedge pclk);
    tx_pos <= {1'b1, o, f, b};
    rx_pos <= {1'b1, o, f, b};
    @(posedge pclk);
    tx_pos.strobe <= 1'b0;
    rx_pos.strobe <= 1'b0;
    @(posedge pclk);
    ser_seen = rx_serial_payload_out;
    lapd_seen = rx_lapd_valid;
    repeat (8) @(posedge pclk);
  endtask

  task automatic t_regs();
    logic [31:0] rd;
    logic e;
    apb(1'b0, TX_SEL_OFFS, 32'h0, rd, e);
    check(rd, {24'h0, TX_SEL_RESET});
    apb(1'b1, RX_SEL_OFFS, 32'hFFFF_FFFF, rd, e);
    apb(1'b0, RX_SEL_OFFS, 32'h0, rd, e);
    check(rd, 32'h0000_0033);
    check({31'h0, e}, 32'h0);
    apb(1'b0, 8'h0C, 32'h0, rd, e);
    check({31'h0, e}, 32'h1);
    check(rd, 32'h0);
  endtask

  function automatic logic sel(odl_fmt_e f, logic [1:0] bw, int i);
    if (f == ODL_FMT_T1DM) return 1'b1;
    if (f != ODL_FMT_ESF) return (i % 2) == 0;
    if (bw == 2'h1) return (i % 4) == 1;
    if (bw == 2'h2) return (i % 4) == 3;
    return (i % 2) == 1;
  endfunction

  task automatic t_sweep(input odl_fmt_e f, input logic [1:0] bw, input int nf, input int en);
    int t0, r0, v0;
    logic q[$];
    fmt <= f;
    setup({2'h0, bw, 4'h3}, {2'h0, bw, 4'h2});
    far_end.rx_got.delete();
    t0 = n_txclk;
    r0 = n_rxclk;
    v0 = n_txv;
    for (int i = 1; i <= nf; i++) begin
      step(1'b0, i[4:0], 1'b0);
      step(1'b1, i[4:0], i[1]);
      if (sel(f, bw, i)) q.push_back(i[1]);
    end
    repeat (40) @(posedge pclk);
    check(n_txclk - t0, en);
    check(n_rxclk - r0, en);
    check(n_txv - v0, en);
    check(far_end.rx_got.size(), q.size());
    for (int k = 0; k < q.size() && k < far_end.rx_got.size(); k++)
      check(far_end.rx_got[k], q[k]);
  endtask

  task automatic t_txsrc();
    logic exp;
    fmt <= ODL_FMT_T1DM;
    for (int s = 0; s < 4; s++) begin
      setup({6'h0, s[1:0]}, 8'h01);
      for (int j = 0; j < 2; j++) begin
        tx_lapd_bit <= j[0];
        tx_serial_payload_in <= ~j[0];
        repeat (4) @(posedge pclk);
        exp = (s == 0) ? j[0] : (s == 1) ? ~j[0] : (s == 2) ? tx_overhead_data_in : 1'b1;
        step(1'b1, 5'd1, 1'b0);
        check(tx_dl_bit, exp);
      end
    end
  endtask

  task automatic t_rxdst();
    int r0, l0;
    fmt <= ODL_FMT_T1DM;
    for (int d = 0; d < 4; d++) begin
      setup(8'h03, {6'h0, d[1:0]});
      r0 = n_rxclk;
      l0 = n_lapd;
      // alternate bit so a held or forced value cannot pass by accident
      step(1'b1, 5'd2, ~d[0]);
      repeat (10) @(posedge pclk);
      check(ser_seen, (d == 3) || (d % 2 == 0));
      check(lapd_seen, d == 0);
      check(n_lapd - l0, d == 0);
      check(n_rxclk - r0, d == 2);
      if (d == 0) check(rx_lapd_bit, 1'b1);
    end
  endtask

  // pushes faster than the port drains, so the FIFO must fill and refuse
  task automatic t_fifo();
    logic q[$];
    logic full;
    full = 1'b0;
    setup(8'h03, 8'h02);
    far_end.rx_got.delete();
    for (int i = 0; i < 8; i++) begin
      @(posedge pclk);
      if (rx_core_ready === 1'b1) begin
        rx_pos <= {1'b1, 1'b1, 5'd3, i[0] ^ i[2]};
        q.push_back(i[0] ^ i[2]);
      end else begin
        full = 1'b1;
      end
      @(posedge pclk);
      rx_pos.strobe <= 1'b0;
    end
    repeat (120) @(posedge pclk);
    check(full, 1'b1);
    check(far_end.rx_got.size(), q.size());
    for (int k = 0; k < q.size() && k < far_end.rx_got.size(); k++)
      check(far_end.rx_got[k], q[k]);
  endtask

  // reset in mid-run: pins go idle and both selects return to their reset value
  task automatic t_reset();
    logic [31:0] rd;
    logic e;
    setup(8'h13, 8'h12);
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (4) @(posedge pclk);
    check({tx_overhead_clock, rx_overhead_clock, rx_overhead_data_out, tx_dl_bit},
          32'h0000_0003);
    presetn <= 1'b1;
    apb(1'b0, TX_SEL_OFFS, 32'h0, rd, e);
    check(rd, {24'h0, TX_SEL_RESET});
    apb(1'b0, RX_SEL_OFFS, 32'h0, rd, e);
    check(rd, {24'h0, RX_SEL_RESET});
  endtask

  initial begin
    #(40 * 30000);
    miscompares++;
    test_done();
  end

  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_sweep(ODL_FMT_ESF, 2'h0, 24, 12);
    t_sweep(ODL_FMT_ESF, 2'h1, 24, 6);
    t_sweep(ODL_FMT_ESF, 2'h2, 24, 6);
    t_sweep(ODL_FMT_SF, 2'h0, 12, 6);
    t_sweep(ODL_FMT_N, 2'h0, 12, 6);
    t_sweep(ODL_FMT_T1DM, 2'h0, 12, 12);
    t_txsrc();
    t_rxdst();
    t_fifo();
    t_reset();
    test_done();
  end
endmodule

// [verilog/odl_pkg.sv]
/*
  Shared constants, types and the link-bit position decoder for the DS1 overhead
  data-link port. Assumes a 25 MHz pclk and a framer core on the same clock.
*/
package odl_pkg;

  // timing: overhead clock phases, least times rounded up to whole pclk cycles
  localparam int PCLK_PERIOD_NS  = 40;
  localparam int OH_CLK_HIGH_NS  = 160;
  localparam int OH_CLK_LOW_NS   = 160;
  localparam int OH_CLK_HIGH_CYC = (OH_CLK_HIGH_NS + PCLK_PERIOD_NS - 1) / PCLK_PERIOD_NS;
  localparam int OH_CLK_LOW_CYC  = (OH_CLK_LOW_NS + PCLK_PERIOD_NS - 1) / PCLK_PERIOD_NS;
  // pin synchroniser depth; the low phase must outlast it
  localparam int SYNC_STAGES     = 2;

  // register byte offsets
  localparam logic [7:0] TX_SEL_OFFS = 8'h00;
  localparam logic [7:0] RX_SEL_OFFS = 8'h04;
  localparam logic [7:0] STATUS_OFFS = 8'h08;

  // select register fields
  localparam int         SRC_LSB      = 0;
  localparam int         BW_LSB       = 4;
  localparam logic [7:0] SEL_WMASK    = 8'h33;
  localparam logic [7:0] TX_SEL_RESET = 8'h00;
  localparam logic [7:0] RX_SEL_RESET = 8'h00;

  // status register fields
  localparam int STAT_LEVEL_LSB = 0;
  localparam int STAT_RX_BUSY   = 3;
  localparam int STAT_TX_HOLD   = 4;

  // transmit source codes
  localparam logic [1:0] SRC_INTERNAL = 2'h0;
  localparam logic [1:0] SRC_SERIAL   = 2'h1;
  localparam logic [1:0] SRC_OVERHEAD = 2'h2;
  localparam logic [1:0] SRC_ONES     = 2'h3;

  // receive destination codes
  localparam logic [1:0] DST_INTERNAL = 2'h0;
  localparam logic [1:0] DST_SERIAL   = 2'h1;
  localparam logic [1:0] DST_OVERHEAD = 2'h2;
  localparam logic [1:0] DST_ONES     = 2'h3;

  // ESF bandwidth codes
  localparam logic [1:0] BW_ALL  = 2'h0;
  localparam logic [1:0] BW_ODD  = 2'h1;
  localparam logic [1:0] BW_EVEN = 2'h2;

  localparam int FIFO_WIDTH = 1;
  localparam int FIFO_DEPTH = 4;

  typedef enum logic [1:0] {
    ODL_FMT_ESF,
    ODL_FMT_SF,
    ODL_FMT_N,
    ODL_FMT_T1DM
  } odl_fmt_e;

  // one bit position from the framer core
  typedef struct packed {
    logic       strobe;
    logic       overhead;
    logic [4:0] frame_num;
    logic       bit_val;
  } odl_pos_s;

  // true when an overhead position carries a selected data-link bit
  function automatic logic odl_is_link_bit(odl_fmt_e fmt, logic [4:0] frame_num,
                                           logic [1:0] bw);
    logic sel;
    sel = 1'b0;
    unique case (fmt)
      ODL_FMT_ESF: begin
        if (bw == BW_ODD) begin
          sel = frame_num[0] & ~frame_num[1];
        end else if (bw == BW_EVEN) begin
          sel = frame_num[0] & frame_num[1];
        end else begin
          sel = frame_num[0];
        end
      end
      ODL_FMT_SF, ODL_FMT_N: begin
        sel = ~frame_num[0];
      end
      ODL_FMT_T1DM: begin
        sel = 1'b1;
      end
    endcase
    return sel;
  endfunction

endpackage

// [verilog/odl_port.sv]
/*
  DS1 overhead data-link port: APB registers, transmit link-bit source select with
  the transmit overhead clock, receive link-bit steering with a 4-word FIFO feeding
  the receive overhead serial port. Assumes the framer core drives the position
  strobes on pclk and that overhead pins come from another clock domain.
*/
// Implementation choices: the address map and the APB interface to the registers.
// Summary of operation
// [R1] tx source 00 takes link bits from the internal controller input
// [R2] tx source 01 takes link bits from the transmit serial payload pin
// [R3] tx source 10 takes link bits from the transmit overhead data pin
// [R4] tx source 11 sends every link bit as one
// [R5] T1DM carries one link bit per frame, an 8 kHz channel
// [R6] rx port delivers FDL in ESF, Fs in N and SF, R bits in T1DM
// [R7] rx overhead clock rises once per selected link bit under rx destination 10; a bit that finds the FIFO full is dropped and gets no rise
// [R8] rx overhead data changes together with the rx overhead clock rise
// [R9] far end samples rx overhead data on the clock's falling edge
// [R10] rx destination 00 feeds internal controller and the serial output
// [R11] rx destination 01 feeds only the serial payload output
// [R12] rx destination 10 feeds the overhead pin and the serial output
// [R13] rx destination 11 forces extracted link bits to one
// [R14] ESF link bandwidth selectable between 4 kHz and 2 kHz
// [R15] bandwidth 00 all FDL bits, 01 frames 1,5,9, 10 frames 3,7,11
// [R16] tx overhead data sampled at the falling edge of our tx clock
// [R17] far end updates tx overhead data after each tx clock rise
// [R18] overhead clocks stay idle at positions without a link bit

module odl_fifo #(
  parameter int WIDTH = 1,
  parameter int DEPTH = 4
) (
  input  wire logic                       pclk,
  input  wire logic                       presetn,
  input  wire logic                       in_valid,
  output logic                            in_ready,
  input  wire logic [WIDTH-1:0]           in_data,
  output logic                            out_valid,
  input  wire logic                       out_ready,
  output logic [WIDTH-1:0]                out_data,
  output logic [$clog2(DEPTH+1)-1:0]      level
);
  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH+1);
  localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);
  localparam logic [PW-1:0] LAST_PTR = PW'(DEPTH - 1);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [PW-1:0]    wr_ptr_q;
  logic [PW-1:0]    rd_ptr_q;
  logic [CW-1:0]    cnt_q;
  logic             ready_q;
  logic             push;
  logic             pop;

  assign push      = in_valid & ready_q;
  assign pop       = out_ready & (cnt_q != '0);
  assign in_ready  = ready_q;
  assign out_valid = (cnt_q != '0);
  assign out_data  = mem_q[rd_ptr_q];
  assign level     = cnt_q;

  always_ff @(posedge pclk) begin
    if (push) begin
      mem_q[wr_ptr_q] <= in_data;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
    end else begin
      if (push) begin
        wr_ptr_q <= (wr_ptr_q == LAST_PTR) ? '0 : wr_ptr_q + 1'b1;
      end
      if (pop) begin
        rd_ptr_q <= (rd_ptr_q == LAST_PTR) ? '0 : rd_ptr_q + 1'b1;
      end
    end
  end

  // ready kept as a flop so the core sees a registered stall
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q   <= '0;
      ready_q <= 1'b0;
    end else begin
      unique case ({push, pop})
        2'b10: begin
          cnt_q   <= cnt_q + 1'b1;
          ready_q <= (cnt_q + 1'b1) != FULL_CNT;
        end
        2'b01: begin
          cnt_q   <= cnt_q - 1'b1;
          ready_q <= 1'b1;
        end
        default: begin
          ready_q <= cnt_q != FULL_CNT;
        end
      endcase
    end
  end
endmodule

module odl_port (
  input  wire logic            pclk,
  input  wire logic            presetn,
  input  wire logic            psel,
  input  wire logic            penable,
  input  wire logic            pwrite,
  input  wire logic [7:0]      paddr,
  input  wire logic [31:0]     pwdata,
  output logic [31:0]          prdata,
  output logic                 pready,
  output logic                 pslverr,
  input  wire odl_pkg::odl_fmt_e fmt,
  input  wire odl_pkg::odl_pos_s tx_pos,
  input  wire logic            tx_lapd_bit,
  output logic                 tx_dl_valid,
  output logic                 tx_dl_bit,
  input  wire logic            tx_serial_payload_in,
  input  wire logic            tx_overhead_data_in,
  output logic                 tx_overhead_clock,
  input  wire odl_pkg::odl_pos_s rx_pos,
  output logic                 rx_core_ready,
  output logic                 rx_lapd_valid,
  output logic                 rx_lapd_bit,
  output logic                 rx_serial_payload_out,
  output logic                 rx_overhead_clock,
  output logic                 rx_overhead_data_out
);
  import odl_pkg::*;

  typedef enum {ODL_IDLE, ODL_HIGH, ODL_LOW} odl_ph_e;

  logic [7:0]  tx_sel_q;
  logic [7:0]  rx_sel_q;
  logic [31:0] prdata_q;
  logic        pready_q;
  logic        pslverr_q;
  logic [1:0]  pin_s1_q;
  logic [1:0]  pin_s2_q;
  logic        tx_valid_q;
  logic        tx_bit_q;
  logic        tx_clk_q;
  odl_ph_e     tx_ph_q;
  logic [3:0]  tx_cnt_q;
  logic        tx_hold_q;
  logic        rx_ser_q;
  logic        rx_lapd_v_q;
  logic        rx_lapd_b_q;
  logic        rx_clk_q;
  logic        rx_data_q;
  odl_ph_e     rx_ph_q;
  logic [3:0]  rx_cnt_q;
  logic        fifo_ready;
  logic        fifo_out_valid;
  logic        fifo_out_ready;
  logic [0:0]  fifo_out_data;
  logic [2:0]  fifo_level;
  logic [1:0]  tx_src;
  logic [1:0]  tx_bw;
  logic [1:0]  rx_dst;
  logic [1:0]  rx_bw;
  logic        tx_link;
  logic        rx_link;
  logic        rx_dl_val;
  logic        acc;
  logic        addr_ok;
  logic        tx_ser_sync;
  logic        tx_oh_sync;

  assign tx_src      = tx_sel_q[SRC_LSB +: 2];
  assign tx_bw       = tx_sel_q[BW_LSB +: 2];
  assign rx_dst      = rx_sel_q[SRC_LSB +: 2];
  assign rx_bw       = rx_sel_q[BW_LSB +: 2];
  assign tx_ser_sync = pin_s2_q[0];
  assign tx_oh_sync  = pin_s2_q[1];
  // ESF positions filtered by bandwidth, SF and N by frame parity, T1DM takes every frame
  assign tx_link = tx_pos.strobe & tx_pos.overhead
                 & odl_is_link_bit(fmt, tx_pos.frame_num, tx_bw);          // see [R15]
  assign rx_link = rx_pos.strobe & rx_pos.overhead
                 & odl_is_link_bit(fmt, rx_pos.frame_num, rx_bw);          // see [R6] [R14]
  assign rx_dl_val = (rx_dst == DST_ONES) ? 1'b1 : rx_pos.bit_val;         // see [R13]

  // apb: access phase lasts two cycles, pready from a flop
  assign acc     = psel & penable;
  assign addr_ok = (paddr == TX_SEL_OFFS) | (paddr == RX_SEL_OFFS) | (paddr == STATUS_OFFS);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
    end else if (acc && !pready_q) begin
      pready_q  <= 1'b1;
      pslverr_q <= ~addr_ok;
      unique case (paddr)
        TX_SEL_OFFS: prdata_q <= {24'h00_0000, tx_sel_q};
        RX_SEL_OFFS: prdata_q <= {24'h00_0000, rx_sel_q};
        STATUS_OFFS: begin
          prdata_q <= 32'h0000_0000;
          prdata_q[STAT_LEVEL_LSB +: 3] <= fifo_level;
          prdata_q[STAT_RX_BUSY]        <= (rx_ph_q != ODL_IDLE);
          prdata_q[STAT_TX_HOLD]        <= tx_hold_q;
        end
        default: prdata_q <= 32'h0000_0000;
      endcase
    end else begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_sel_q <= TX_SEL_RESET;
      rx_sel_q <= RX_SEL_RESET;
    end else if (acc && pready_q && pwrite) begin
      if (paddr == TX_SEL_OFFS) begin
        tx_sel_q <= pwdata[7:0] & SEL_WMASK;
      end
      if (paddr == RX_SEL_OFFS) begin
        rx_sel_q <= pwdata[7:0] & SEL_WMASK;
      end
    end
  end

  // pin synchroniser; only the second stage is read
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_s1_q <= 2'h0;
      pin_s2_q <= 2'h0;
    end else begin
      pin_s1_q <= {tx_overhead_data_in, tx_serial_payload_in};
      pin_s2_q <= pin_s1_q;
    end
  end

  // transmit link bit to the core, one cycle after each link position
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_valid_q <= 1'b0;
      tx_bit_q   <= 1'b1;
    end else begin
      tx_valid_q <= tx_link;                                               // see [R5]
      if (tx_link) begin
        unique case (tx_src)
          SRC_INTERNAL: tx_bit_q <= tx_lapd_bit;                           // see [R1]
          SRC_SERIAL:   tx_bit_q <= tx_ser_sync;                           // see [R2]
          SRC_OVERHEAD: tx_bit_q <= tx_hold_q;                             // see [R3]
          SRC_ONES:     tx_bit_q <= 1'b1;                                  // see [R4]
        endcase
      end
    end
  end

  // tx overhead clock: one pulse per link position; the far end answers the rise,
  // and the capture waits out the synchroniser after our fall
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_clk_q  <= 1'b0;
      tx_ph_q   <= ODL_IDLE;
      tx_cnt_q  <= 4'h0;
      tx_hold_q <= 1'b1;
    end else begin
      unique case (tx_ph_q)
        ODL_IDLE: begin
          if (tx_link) begin
            tx_clk_q <= 1'b1;                                              // see [R16] [R18]
            tx_cnt_q <= 4'h0;
            tx_ph_q  <= ODL_HIGH;
          end
        end
        ODL_HIGH: begin
          if (tx_cnt_q == 4'(OH_CLK_HIGH_CYC - 1)) begin
            tx_clk_q <= 1'b0;
            tx_cnt_q <= 4'h0;
            tx_ph_q  <= ODL_LOW;
          end else begin
            tx_cnt_q <= tx_cnt_q + 4'h1;
          end
        end
        ODL_LOW: begin
          if (tx_cnt_q == 4'(SYNC_STAGES)) begin
            tx_hold_q <= tx_oh_sync;                                       // see [R16] [R17]
          end
          if (tx_cnt_q == 4'(OH_CLK_LOW_CYC - 1)) begin
            tx_ph_q <= ODL_IDLE;
          end else begin
            tx_cnt_q <= tx_cnt_q + 4'h1;
          end
        end
      endcase
    end
  end

  // receive serial output passes payload and substitutes link bits
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_ser_q    <= 1'b1;
      rx_lapd_v_q <= 1'b0;
      rx_lapd_b_q <= 1'b1;
    end else begin
      rx_lapd_v_q <= rx_link & (rx_dst == DST_INTERNAL);                   // see [R10] [R11]
      if (rx_link) begin
        rx_ser_q    <= rx_dl_val;                                          // see [R10] [R11] [R12]
        rx_lapd_b_q <= rx_dl_val;
      end else if (rx_pos.strobe) begin
        rx_ser_q <= rx_pos.bit_val;
      end
    end
  end

  // full fifo drops the bit; the core sees rx_core_ready low beforehand
  odl_fifo #(
    .WIDTH (FIFO_WIDTH),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .pclk      (pclk),
    .presetn   (presetn),
    .in_valid  (rx_link & (rx_dst == DST_OVERHEAD)),                       // see [R12]
    .in_ready  (fifo_ready),
    .in_data   (rx_pos.bit_val),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_out_ready),
    .out_data  (fifo_out_data),
    .level     (fifo_level)
  );

  assign rx_core_ready  = fifo_ready;
  assign fifo_out_ready = (rx_ph_q == ODL_IDLE);

  // rx overhead port: data and clock rise together, far end samples at the fall
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_clk_q  <= 1'b0;
      rx_data_q <= 1'b1;
      rx_ph_q   <= ODL_IDLE;
      rx_cnt_q  <= 4'h0;
    end else begin
      unique case (rx_ph_q)
        ODL_IDLE: begin
          if (fifo_out_valid) begin
            rx_clk_q  <= 1'b1;                                             // see [R7] [R18]
            rx_data_q <= fifo_out_data[0];                                 // see [R8] [R9]
            rx_cnt_q  <= 4'h0;
            rx_ph_q   <= ODL_HIGH;
          end
        end
        ODL_HIGH: begin
          if (rx_cnt_q == 4'(OH_CLK_HIGH_CYC - 1)) begin
            rx_clk_q <= 1'b0;
            rx_cnt_q <= 4'h0;
            rx_ph_q  <= ODL_LOW;
          end else begin
            rx_cnt_q <= rx_cnt_q + 4'h1;
          end
        end
        ODL_LOW: begin
          if (rx_cnt_q == 4'(OH_CLK_LOW_CYC - 1)) begin
            rx_ph_q <= ODL_IDLE;
          end else begin
            rx_cnt_q <= rx_cnt_q + 4'h1;
          end
        end
      endcase
    end
  end

  assign prdata                = prdata_q;
  assign pready                = pready_q;
  assign pslverr               = pslverr_q;
  assign tx_dl_valid           = tx_valid_q;
  assign tx_dl_bit             = tx_bit_q;
  assign tx_overhead_clock     = tx_clk_q;
  assign rx_lapd_valid         = rx_lapd_v_q;
  assign rx_lapd_bit           = rx_lapd_b_q;
  assign rx_serial_payload_out = rx_ser_q;
  assign rx_overhead_clock     = rx_clk_q;
  assign rx_overhead_data_out  = rx_data_q;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_pulse_high;
    rx_clk_q [*4];
  endsequence
  sequence s_pulse_low;
    !rx_clk_q [*4];
  endsequence
  sequence s_tx_high;
    tx_clk_q [*4];
  endsequence

  AST_TX_ONES: assert property (tx_link && tx_src == SRC_ONES |=> tx_valid_q && tx_bit_q) // [R4]
    else $error("forced-one source sent a zero");
  AST_TX_INTERNAL: assert property (tx_link && tx_src == SRC_INTERNAL // [R1]
    |=> tx_bit_q == $past(tx_lapd_bit))
    else $error("internal source bit not taken");
  AST_TX_SERIAL: assert property (tx_link && tx_src == SRC_SERIAL // [R2]
    |=> tx_bit_q == $past(tx_ser_sync))
    else $error("serial source bit not taken");
  AST_TX_OVERHEAD: assert property (tx_link && tx_src == SRC_OVERHEAD // [R3]
    |=> tx_bit_q == $past(tx_hold_q))
    else $error("overhead source bit not taken");
  AST_T1DM_RATE: assert property (tx_pos.strobe && tx_pos.overhead && fmt == ODL_FMT_T1DM // [R5]
    |=> tx_valid_q)
    else $error("t1dm frame without link bit");
  AST_TX_CLK_SHAPE: assert property ($rose(tx_clk_q) |-> s_tx_high ##1 !tx_clk_q) // [R16]
    else $error("tx overhead clock pulse width wrong");
  AST_TX_CLK_CAUSE: assert property ($rose(tx_clk_q) |-> $past(tx_link)) // [R18]
    else $error("tx overhead clock rose without a link bit");
  AST_RX_CLK_SHAPE: assert property ($rose(rx_clk_q) |-> s_pulse_high ##1 s_pulse_low) // [R7]
    else $error("rx overhead clock pulse shape wrong");
  AST_RX_DATA_EDGE: assert property ($changed(rx_data_q) |-> $rose(rx_clk_q)) // [R8]
    else $error("rx overhead data moved off the clock rise");
  AST_RX_ONES: assert property (rx_link && rx_dst == DST_ONES |=> rx_ser_q) // [R13]
    else $error("forced-one destination passed a zero");
  AST_RX_LAPD_DST: assert property (rx_lapd_v_q |-> $past(rx_dst) == DST_INTERNAL) // [R10]
    else $error("internal controller fed outside destination 00");
  AST_RX_BW_ODD: assert property (rx_link && fmt == ODL_FMT_ESF && rx_bw == BW_ODD // [R15]
    |-> rx_pos.frame_num[1:0] == 2'h1)
    else $error("odd bandwidth used a wrong frame");

endmodule
